/* rtl/adc_power_sleep_format_ctrl.sv */
`timescale 1ns/10ps
// Summary of operation
// - Module-on set: converter powered and active until switched off after sleep
// - Module-on clear: analog and digital disabled
// - Sleep stops converter clock unless RC, held low
// - Sleep aborts non-RC conversion, never resumed
// - Sleep leaves register contents unchanged
// - RC clock converts in sleep, one-cycle delay
// - RC completion clears active flag, stores result
// - Enabled interrupt: sleep completion wakes device
// - Disabled interrupt: converter off, module-on stays
// - Stop-in-idle selects halt or run in idle
// - Reset clears registers, aborts any sequence
// - Reset leaves result buffer untouched
// - Buffer undefined after power-on
// - 12-bit words read in four formats
// - Reads 16 bits: extend or left-justify
// - Buffer writes always right-justified integer
// - Port reads zero on analog pins
// - Digital pins supply no analog value
// - Hold capacitor discharged before each sample
// - Aborted conversion keeps last buffer value
// - Sixteen read-only words filled by converter
module adc_power_sleep_format_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cpu_sleep,
   input wire logic cpu_idle,
   input wire logic [15:0] port_pins_in,
   input wire logic [11:0] sar_result,
   output logic analog_power_en,
   output logic conversion_active_clk_en,
   output logic hold_discharge,
   output logic sample_switch,
   output logic [3:0] mux_select,
   output logic wake_request
);
   logic [6:0] ctrl_ff;
   logic [3:0] chan_ff;
   logic [15:0] pcfg_ff;
   logic [11:0] result_buffer [0:15];
   logic [3:0] wr_ptr_ff;
   logic done_ff;
   logic sleep_off_ff;
   logic wake_ff;
   logic [3:0] cnt_ff;
   adc_ctrl_pkg::conversion_active_state_t state_ff;
   adc_ctrl_pkg::conversion_active_state_t nxt_state;
   logic [3:0] nxt_cnt;
   logic [7:0] a_addr_ff;
   logic a_wr_ff;
   logic [31:0] hrdata_ff;
   logic module_on;
   logic active;
   logic halted;
   logic abort;
   logic finish;
   logic wr_ctrl;
   logic addr_phase;
   logic [11:0] conversion_active_sample;

   // Format a 12-bit word onto the low 16 bits of the 32-bit bus
   function automatic logic [15:0] fmt_word(input logic [11:0] d, input logic [1:0] f);
      logic [15:0] r;
      r = {4'h0, d};
      case (f)
         adc_ctrl_pkg::FMT_INT: r = {4'h0, d};
         adc_ctrl_pkg::FMT_SINT: r = {{4{d[11]}}, d};
         adc_ctrl_pkg::FMT_FRAC: r = {d, 4'h0};
         adc_ctrl_pkg::FMT_SFRAC: r = {d, 4'h0};
         default: r = {4'h0, d};
      endcase
      return r;
   endfunction

   assign module_on = ctrl_ff[adc_ctrl_pkg::CTRL_ON];
   assign active = module_on && !sleep_off_ff;
   assign analog_power_en = active;
   assign halted = cpu_idle && ctrl_ff[adc_ctrl_pkg::CTRL_SIDL];
   // clock gated in sleep unless RC
   assign conversion_active_clk_en = active && !halted
      && (!cpu_sleep || ctrl_ff[adc_ctrl_pkg::CTRL_RC]);
   assign abort = !active || (cpu_sleep && !ctrl_ff[adc_ctrl_pkg::CTRL_RC]);
   assign finish = (state_ff == adc_ctrl_pkg::ST_CONVERT) && !abort && !halted
      && (cnt_ff == adc_ctrl_pkg::CONVERSION_ACTIVE_LAST);
   assign hold_discharge = (state_ff == adc_ctrl_pkg::ST_DISCH);
   assign sample_switch = (state_ff == adc_ctrl_pkg::ST_SAMPLE);
   assign mux_select = chan_ff;
   assign conversion_active_sample = pcfg_ff[chan_ff] ? 12'h000 : sar_result;
   assign wake_request = wake_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;
   assign addr_phase = hsel && hready
      && (htrans == adc_ctrl_pkg::HTRANS_NONSEQ || htrans == adc_ctrl_pkg::HTRANS_SEQ);
   assign wr_ctrl = a_wr_ff && (a_addr_ff == adc_ctrl_pkg::OFS_CTRL);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      if (abort)
      begin
         nxt_state = adc_ctrl_pkg::ST_IDLE;
         nxt_cnt = 4'h0;
      end
      else if (!halted)
      begin
         case (state_ff)
            adc_ctrl_pkg::ST_IDLE:
               if (ctrl_ff[adc_ctrl_pkg::CTRL_SAMPLE_START])
                  nxt_state = adc_ctrl_pkg::ST_DISCH;
            adc_ctrl_pkg::ST_DISCH:
               nxt_state = adc_ctrl_pkg::ST_SAMPLE;
            adc_ctrl_pkg::ST_SAMPLE:
               if (!ctrl_ff[adc_ctrl_pkg::CTRL_SAMPLE_START])
               begin
                  nxt_cnt = 4'h0;
                  if (ctrl_ff[adc_ctrl_pkg::CTRL_RC])
                     nxt_state = adc_ctrl_pkg::ST_DELAY;
                  else
                     nxt_state = adc_ctrl_pkg::ST_CONVERT;
               end
            // one instruction cycle before RC conversion
            adc_ctrl_pkg::ST_DELAY:
               if (cnt_ff == adc_ctrl_pkg::DLY_LAST - 4'h1)
               begin
                  nxt_state = adc_ctrl_pkg::ST_CONVERT;
                  nxt_cnt = 4'h0;
               end
               else
                  nxt_cnt = cnt_ff + 4'h1;
            adc_ctrl_pkg::ST_CONVERT:
               if (cnt_ff == adc_ctrl_pkg::CONVERSION_ACTIVE_LAST)
               begin
                  nxt_state = adc_ctrl_pkg::ST_IDLE;
                  nxt_cnt = 4'h0;
               end
               else
                  nxt_cnt = cnt_ff + 4'h1;
            default:
               nxt_state = adc_ctrl_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_ff <= adc_ctrl_pkg::ST_IDLE;
         cnt_ff <= 4'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // buffer has no reset and no initial value
   always_ff @(posedge hclk)
   begin
      if (finish)
         result_buffer[wr_ptr_ff] <= conversion_active_sample;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wr_ptr_ff <= 4'h0;
      else if (finish)
         wr_ptr_ff <= wr_ptr_ff + 4'h1;
   end

   // Done flag, set wins over clear by control write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         done_ff <= 1'b0;
      else if (finish)
         done_ff <= 1'b1;
      else if (wr_ctrl && hwdata[adc_ctrl_pkg::CTRL_SAMPLE_START])
         done_ff <= 1'b0;
   end

   // sleep completion: wake or switch off
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sleep_off_ff <= 1'b0;
         wake_ff <= 1'b0;
      end
      else
      begin
         wake_ff <= finish && cpu_sleep && ctrl_ff[adc_ctrl_pkg::CTRL_IE];
         if (!module_on)
            sleep_off_ff <= 1'b0;
         else if (finish && cpu_sleep && !ctrl_ff[adc_ctrl_pkg::CTRL_IE])
            sleep_off_ff <= 1'b1;
      end
   end

   // Bus address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_addr_ff <= 8'h00;
         a_wr_ff <= 1'b0;
      end
      else
      begin
         a_addr_ff <= haddr[7:0];
         a_wr_ff <= addr_phase && hwrite;
      end
   end

   // registers change only on bus writes or reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_ff <= adc_ctrl_pkg::CTRL_RST;
         chan_ff <= 4'h0;
         pcfg_ff <= 16'h0000;
      end
      else if (a_wr_ff)
      begin
         case (a_addr_ff)
            adc_ctrl_pkg::OFS_CTRL: ctrl_ff <= hwdata[adc_ctrl_pkg::CTRL_W-1:0];
            adc_ctrl_pkg::OFS_CHAN: chan_ff <= hwdata[3:0];
            adc_ctrl_pkg::OFS_PCFG: pcfg_ff <= hwdata[15:0];
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // Read data registered during the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_ff <= 32'h0000_0000;
      else if (addr_phase && !hwrite)
      begin
         hrdata_ff <= 32'h0000_0000;
         if (haddr[7:0] < adc_ctrl_pkg::OFS_CTRL)
            hrdata_ff <= {16'h0000, fmt_word(result_buffer[haddr[5:2]],
               ctrl_ff[adc_ctrl_pkg::CTRL_FMT_LO +: 2])};
         else
            case (haddr[7:0])
               adc_ctrl_pkg::OFS_CTRL: hrdata_ff <= {25'h0, ctrl_ff};
               adc_ctrl_pkg::OFS_CHAN: hrdata_ff <= {28'h0, chan_ff};
               adc_ctrl_pkg::OFS_PCFG: hrdata_ff <= {16'h0, pcfg_ff};
               adc_ctrl_pkg::OFS_STAT: hrdata_ff <= {28'h0, active, done_ff,
                  sample_switch, state_ff == adc_ctrl_pkg::ST_CONVERT};
               adc_ctrl_pkg::OFS_PORT: hrdata_ff <= {16'h0, port_pins_in & pcfg_ff};
               default: hrdata_ff <= 32'h0000_0000;
            endcase
      end
   end

   sequence s_sample_end;
      state_ff == adc_ctrl_pkg::ST_SAMPLE && !ctrl_ff[adc_ctrl_pkg::CTRL_SAMPLE_START]
         && !abort && !halted;
   endsequence

   sequence s_full_conversion_active;
      (state_ff == adc_ctrl_pkg::ST_CONVERT && !abort && !halted) [*8];
   endsequence

   a_off_no_power: assert property (@(posedge hclk) disable iff (!hresetn)
      !module_on |-> !analog_power_en && !conversion_active_clk_en)
      else $error("power on while module off");
   a_sleep_clk_low: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_sleep && !ctrl_ff[adc_ctrl_pkg::CTRL_RC] |-> !conversion_active_clk_en)
      else $error("clock running in sleep");
   a_sleep_abort: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_sleep && !ctrl_ff[adc_ctrl_pkg::CTRL_RC] && state_ff != adc_ctrl_pkg::ST_IDLE
      |=> state_ff == adc_ctrl_pkg::ST_IDLE)
      else $error("conversion not aborted by sleep");
   a_rc_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      s_sample_end ##0 ctrl_ff[adc_ctrl_pkg::CTRL_RC] |=>
      state_ff == adc_ctrl_pkg::ST_DELAY)
      else $error("no delay before rc conversion");
   a_discharge_first: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(sample_switch) |-> $past(hold_discharge))
      else $error("sampling without discharge");
   a_sleep_wake: assert property (@(posedge hclk) disable iff (!hresetn)
      finish && cpu_sleep && ctrl_ff[adc_ctrl_pkg::CTRL_IE] |=> wake_request)
      else $error("no wake on completion");
   a_sleep_off: assert property (@(posedge hclk) disable iff (!hresetn)
      finish && cpu_sleep && !ctrl_ff[adc_ctrl_pkg::CTRL_IE] && module_on
      |=> !analog_power_en && module_on)
      else $error("converter not off after sleep conversion");
   a_idle_halt: assert property (@(posedge hclk) disable iff (!hresetn)
      halted && !abort |=> $stable(state_ff) && $stable(cnt_ff))
      else $error("sequence moved while halted in idle");
   a_abort_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
      abort |-> !finish ##1 $stable(wr_ptr_ff))
      else $error("buffer written by aborted conversion");
   a_conversion_active_length: assert property (@(posedge hclk) disable iff (!hresetn)
      s_full_conversion_active ##1 (state_ff == adc_ctrl_pkg::ST_CONVERT && !abort && !halted) [*7]
      |=> state_ff == adc_ctrl_pkg::ST_IDLE && done_ff)
      else $error("conversion did not complete in time");
   a_port_analog: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[7:0] == adc_ctrl_pkg::OFS_PORT
      |=> (hrdata[15:0] & ~$past(pcfg_ff)) == 16'h0000)
      else $error("analog pin read nonzero");
   a_pwr_with_on: assert property (@(posedge hclk) disable iff (!hresetn)
      module_on && !sleep_off_ff
      |-> analog_power_en)
      else $error("converter unpowered while module on");
   a_off_aborts: assert property (@(posedge hclk) disable iff (!hresetn)
      !module_on
      |=> state_ff == adc_ctrl_pkg::ST_IDLE)
      else $error("sequence running while module off");
   a_rc_sleep_run: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_sleep && ctrl_ff[adc_ctrl_pkg::CTRL_RC] && active && !halted
      |-> conversion_active_clk_en)
      else $error("rc clock stopped in sleep");
   a_result_stored: assert property (@(posedge hclk) disable iff (!hresetn)
      finish |=> wr_ptr_ff == $past(wr_ptr_ff) + 4'h1
      && state_ff == adc_ctrl_pkg::ST_IDLE && done_ff)
      else $error("completion not recorded");
   a_no_wake_off: assert property (@(posedge hclk) disable iff (!hresetn)
      finish && cpu_sleep && !ctrl_ff[adc_ctrl_pkg::CTRL_IE]
      |=> !wake_request)
      else $error("wake raised with interrupt disabled");
   a_idle_run: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_idle && !ctrl_ff[adc_ctrl_pkg::CTRL_SIDL] && active && !cpu_sleep
      |-> conversion_active_clk_en)
      else $error("converter halted in idle while set to run");
   a_read_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[7:0] < adc_ctrl_pkg::OFS_CTRL
      |=> hrdata[31:16] == 16'h0000)
      else $error("buffer read wider than sixteen bits");
   a_digital_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      finish && pcfg_ff[chan_ff]
      |=> result_buffer[$past(wr_ptr_ff)] == 12'h000)
      else $error("digital pin produced a conversion value");
   a_discharge_once: assert property (@(posedge hclk) disable iff (!hresetn)
      hold_discharge && !halted
      |=> sample_switch || state_ff == adc_ctrl_pkg::ST_IDLE)
      else $error("discharge not followed by sampling");
endmodule

/* rtl/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_BUF0 = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h40;
   localparam logic [7:0] OFS_CHAN = 8'h44;
   localparam logic [7:0] OFS_PCFG = 8'h48;
   localparam logic [7:0] OFS_STAT = 8'h4C;
   localparam logic [7:0] OFS_PORT = 8'h50;
   // Control register fields
   localparam int CTRL_ON = 0;
   localparam int CTRL_SIDL = 1;
   localparam int CTRL_RC = 2;
   localparam int CTRL_SAMPLE_START = 3;
   localparam int CTRL_FMT_LO = 4;
   localparam int CTRL_IE = 6;
   localparam int CTRL_W = 7;
   localparam logic [6:0] CTRL_RST = 7'h00;
   // Status register fields
   localparam int ST_CONVERSION_ACTIVE = 0;
   localparam int ST_SAMPLE_START = 1;
   localparam int ST_DONE = 2;
   localparam int ST_PWR = 3;
   localparam int ST_W = 4;
   // Output formats
   localparam logic [1:0] FMT_INT = 2'h0;
   localparam logic [1:0] FMT_SINT = 2'h1;
   localparam logic [1:0] FMT_FRAC = 2'h2;
   localparam logic [1:0] FMT_SFRAC = 2'h3;
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int INSTR_CYCLE_NS = 4;
   localparam int INSTR_DELAY = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONVERSION_ACTIVE_TAD = 15;
   localparam logic [3:0] CONVERSION_ACTIVE_LAST = 4'(CONVERSION_ACTIVE_TAD - 1);
   localparam logic [3:0] DLY_LAST = 4'(INSTR_DELAY);
   localparam int BUF_WORDS = 16;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_DISCH = 5'h02,
      ST_SAMPLE = 5'h04,
      ST_DELAY = 5'h08,
      ST_CONVERT = 5'h10
   } conversion_active_state_t;
endpackage

/* tb/analog_core_model.sv */
`timescale 1ns/10ps
module analog_core_model (
   input wire logic hclk,
   input wire logic analog_power_en,
   input wire logic conversion_active_clk_en,
   input wire logic [3:0] mux_select,
   output logic [11:0] sar_result
);
   logic [11:0] junk_ff = 12'h3C3;
   always @(posedge hclk)
   begin
      junk_ff <= ~junk_ff ^ 12'h5A5;
   end
   // pins are inputs
   // Channel number in top bits makes every source distinct
   assign sar_result = (analog_power_en && conversion_active_clk_en) ? {mux_select, 8'h5A} : junk_ff;
endmodule

/* tb/adc_power_sleep_format_ctrl_test.sv */
`timescale 1ns/10ps
module adc_power_sleep_format_ctrl_test;
   logic hclk, hresetn, hsel, hwrite, cpu_sleep, cpu_idle;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, analog_power_en, conversion_active_clk_en, hold_discharge;
   logic sample_switch, wake_request;
   logic [15:0] port_pins_in;
   logic [11:0] sar_result;
   logic [3:0] mux_select;
   int miscompares, n_compared;
   adc_power_sleep_format_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .port_pins_in(port_pins_in),
      .sar_result(sar_result), .analog_power_en(analog_power_en),
      .conversion_active_clk_en(conversion_active_clk_en), .hold_discharge(hold_discharge),
      .sample_switch(sample_switch), .mux_select(mux_select),
      .wake_request(wake_request));
   analog_core_model core (.hclk(hclk), .analog_power_en(analog_power_en),
      .conversion_active_clk_en(conversion_active_clk_en), .mux_select(mux_select), .sar_result(sar_result));
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bounded wait for a condition sampled at each rising edge
   task wait_sig(input int which);
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end while (!((which == 0 && hreadyout === 1'b1) || (which == 1 && hold_discharge === 1'b1)
         || (which == 2 && wake_request === 1'b1) || (which == 3 && analog_power_en === 1'b0))
         && n < 200);
      if (n >= 200)
      begin
         miscompares++;
         wrap_up();
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= adc_ctrl_pkg::HTRANS_NONSEQ;
      hwrite <= 1'b1;
      wait_sig(0);
      htrans <= 2'h0;
      hwdata <= d;
      wait_sig(0);
   endtask
   task rd_reg(input logic [7:0] a);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= adc_ctrl_pkg::HTRANS_NONSEQ;
      hwrite <= 1'b0;
      wait_sig(0);
      htrans <= 2'h0;
      wait_sig(0);
      rd = hrdata;
   endtask
   task wait_done;
      int n;
      n = 0;
      do
      begin
         rd_reg(adc_ctrl_pkg::OFS_STAT);
         n++;
      end while (rd[adc_ctrl_pkg::ST_DONE] !== 1'b1 && n < 60);
      if (n >= 60)
      begin
         miscompares++;
         wrap_up();
      end
   endtask
   function automatic logic [31:0] fmt(input logic [11:0] v, input logic [1:0] f);
      if (f == adc_ctrl_pkg::FMT_INT)
         return {20'h00000, v};
      else if (f == adc_ctrl_pkg::FMT_SINT)
         return {16'h0000, {4{v[11]}}, v};
      return {16'h0000, v, 4'h0};
   endfunction
   task t_reset_values;
      rd_reg(adc_ctrl_pkg::OFS_CTRL);
      chk(rd, 32'h00000000);
      rd_reg(adc_ctrl_pkg::OFS_STAT);
      chk(rd, 32'h00000000);
      chk(analog_power_en, 1'b0);
      rd_reg(8'h60);
      chk(rd, 32'h00000000);
   endtask
   task t_convert;
      wr(adc_ctrl_pkg::OFS_CHAN, 32'h00000008);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000009);
      @(posedge hclk);
      chk(analog_power_en, 1'b1);
      wait_sig(1);
      @(posedge hclk);
      chk(sample_switch, 1'b1);
      repeat (8) @(posedge hclk);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000001);
      wait_done();
      wr(adc_ctrl_pkg::OFS_BUF0, 32'h00000FFF);
      chk({hreadyout, hresp}, 2'b10);
      for (int f = 0; f < 4; f++)
      begin
         wr(adc_ctrl_pkg::OFS_CTRL, {26'h0000000, 2'(f), 4'h1});
         rd_reg(adc_ctrl_pkg::OFS_BUF0);
         chk(rd, fmt(12'h85A, 2'(f)));
      end
   endtask
   task t_sleep_abort;
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000009);
      repeat (8) @(posedge hclk);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000001);
      repeat (3) @(posedge hclk);
      cpu_sleep <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(conversion_active_clk_en, 1'b0);
      cpu_sleep <= 1'b0;
      repeat (30) @(posedge hclk);
      rd_reg(adc_ctrl_pkg::OFS_STAT);
      chk(rd, 32'h00000008);
      rd_reg(adc_ctrl_pkg::OFS_CTRL);
      chk(rd, 32'h00000001);
   endtask
   task t_rc_sleep;
      wr(adc_ctrl_pkg::OFS_CHAN, 32'h00000003);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h0000004D);
      repeat (8) @(posedge hclk);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000045);
      cpu_sleep <= 1'b1;
      wait_sig(2);
      chk(wake_request, 1'b1);
      cpu_sleep <= 1'b0;
      rd_reg(adc_ctrl_pkg::OFS_STAT);
      chk(rd[adc_ctrl_pkg::ST_CONVERSION_ACTIVE], 1'b0);
      rd_reg(adc_ctrl_pkg::OFS_BUF0 + 8'h04);
      chk(rd, 32'h0000035A);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h0000000D);
      repeat (8) @(posedge hclk);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000005);
      cpu_sleep <= 1'b1;
      wait_sig(3);
      chk(analog_power_en, 1'b0);
      cpu_sleep <= 1'b0;
      rd_reg(adc_ctrl_pkg::OFS_CTRL);
      chk(rd, 32'h00000005);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000000);
   endtask
   task t_idle_port;
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000003);
      cpu_idle <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(conversion_active_clk_en, 1'b0);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000001);
      @(posedge hclk);
      chk(conversion_active_clk_en, 1'b1);
      cpu_idle <= 1'b0;
      wr(adc_ctrl_pkg::OFS_PCFG, 32'h000000F0);
      rd_reg(adc_ctrl_pkg::OFS_PORT);
      chk(rd, 32'h000000C0);
      wr(adc_ctrl_pkg::OFS_CHAN, 32'h00000004);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000009);
      repeat (8) @(posedge hclk);
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000001);
      wait_done();
      rd_reg(adc_ctrl_pkg::OFS_BUF0 + 8'h0C);
      chk(rd, 32'h00000000);
   endtask
   task t_reset_mid;
      wr(adc_ctrl_pkg::OFS_CTRL, 32'h00000009);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd_reg(adc_ctrl_pkg::OFS_CTRL);
      chk(rd, 32'h00000000);
      rd_reg(adc_ctrl_pkg::OFS_BUF0);
      chk(rd, 32'h0000085A);
   endtask
   initial
   begin
      miscompares = 0;
      n_compared = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      cpu_sleep = 1'b0;
      cpu_idle = 1'b0;
      port_pins_in = 16'hABCD;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values();
      t_convert();
      t_sleep_abort();
      t_rc_sleep();
      t_idle_port();
      t_reset_mid();
      wrap_up();
   end
endmodule
